// ---- design/pm_pkg.sv ----
package pm_pkg;

    // Clock and timing
    localparam int CLK_NS      = 20;
    localparam int US_NS       = 1000;
    localparam int US_CYC      = US_NS / CLK_NS;
    localparam int WAKE_NS     = 20500;
    localparam int WAKE_CYC    = WAKE_NS / CLK_NS;
    localparam int GS_UNIT_US  = 1000;
    localparam int GS_TICK_CYC = GS_UNIT_US * US_CYC;
    localparam int RCW         = 14;

    // Register byte offsets
    localparam logic [7:0] A_MODE      = 8'h00;
    localparam logic [7:0] A_SLEEP     = 8'h04;
    localparam logic [7:0] A_PORT0     = 8'h08;
    localparam logic [7:0] PORT_STRIDE = 8'h08;
    localparam logic [7:0] REC_OFS     = 8'h04;
    localparam logic [7:0] A_STAT      = 8'h18;
    localparam logic [7:0] A_CPU       = 8'h1C;
    localparam logic [7:0] A_CNT       = 8'h20;

    // Field positions
    localparam int PD_BIT    = 3;
    localparam int LPIEN_BIT = 0;
    localparam int CAN_LO    = 4;
    localparam int CAN_HI    = 5;
    localparam int RP_BIT    = 0;
    localparam int ST_PORT_W = 4;
    localparam int ST_EDET   = 8;
    localparam int ST_CPU    = 9;

    // Reset values
    localparam logic [1:0] MODE_RST  = 2'h0;
    localparam logic [7:0] SLEEP_RST = 8'h10;
    localparam logic [7:0] PCTL_RST  = 8'h01;
    localparam logic [7:0] REC_RST   = 8'h19;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_EDET   = 2'b01
    } pm_mode_t;

    typedef enum logic [1:0] {
        TX_ACTIVE  = 2'b00,
        TX_HOLD    = 2'b01,
        TX_LPI     = 2'b10,
        TX_RECOVER = 2'b11
    } tx_state_t;

    typedef struct packed {
        logic       tx_pending;
        logic       rx_lpi;
        logic       link_10m;
        logic [1:0] cancel_evt;
    } port_in_t;

    typedef struct packed {
        logic       pd;
        logic       lpi_en;
        logic [1:0] can_en;
        logic [7:0] rec_us;
    } port_cfg_t;

    typedef struct packed {
        logic tx_lpi;
        logic tx_ready;
        logic tx_idle_off;
        logic tx_clk_en;
        logic rx_clk_en;
        logic phy_pd;
    } port_out_t;

endpackage

// ---- design/lpi_port_ctrl.sv ----
`timescale 1ns/1ns
module lpi_port_ctrl #(
    parameter int IDLE_CYC  = 64,
    parameter int EARLY_CYC = 32
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Configuration and link side
    input  wire pm_pkg::port_cfg_t cfg,
    input  wire pm_pkg::port_in_t  pin,
    // Port controls and state
    output pm_pkg::port_out_t      pout,
    output pm_pkg::tx_state_t      state
);

    pm_pkg::tx_state_t        state_q;
    pm_pkg::tx_state_t        state_d;
    logic [pm_pkg::RCW-1:0]   cnt_q;
    logic [pm_pkg::RCW-1:0]   cnt_d;
    logic [pm_pkg::RCW-1:0]   rec_cyc;
    logic                     may_lpi;
    logic                     cancel;
    logic                     rx_sleep;

    // Policy inputs
    assign may_lpi  = cfg.lpi_en & ~pin.link_10m & ~cfg.pd;
    assign cancel   = |(pin.cancel_evt & cfg.can_en);
    assign rec_cyc  = pm_pkg::RCW'(cfg.rec_us * pm_pkg::US_CYC);
    assign rx_sleep = pin.rx_lpi & may_lpi;

    // Transmit low-power-idle sequencing
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            pm_pkg::TX_ACTIVE:
            begin
                if (!may_lpi || pin.tx_pending)
                    cnt_d = '0;
                else if (cnt_q == pm_pkg::RCW'(IDLE_CYC - 1))
                begin
                    state_d = pm_pkg::TX_HOLD;
                    cnt_d   = '0;
                end
                else
                    cnt_d = cnt_q + pm_pkg::RCW'(1);
            end
            pm_pkg::TX_HOLD:
            begin
                if (!may_lpi || pin.tx_pending || cancel)
                begin
                    state_d = pm_pkg::TX_ACTIVE;
                    cnt_d   = '0;
                end
                else if (cnt_q == pm_pkg::RCW'(EARLY_CYC - 1))
                begin
                    state_d = pm_pkg::TX_LPI;
                    cnt_d   = '0;
                end
                else
                    cnt_d = cnt_q + pm_pkg::RCW'(1);
            end
            pm_pkg::TX_LPI:
            begin
                if (!may_lpi || pin.tx_pending)
                begin
                    state_d = pm_pkg::TX_RECOVER;
                    cnt_d   = rec_cyc;
                end
            end
            pm_pkg::TX_RECOVER:
            begin
                if (cnt_q == '0)
                    state_d = pm_pkg::TX_ACTIVE;
                else
                    cnt_d = cnt_q - pm_pkg::RCW'(1);
            end
        endcase
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= pm_pkg::TX_ACTIVE;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Port controls; frames wait, never dropped, while waking
    assign pout.tx_lpi      = (state_q == pm_pkg::TX_LPI);
    assign pout.tx_ready    = ~cfg.pd & ~state_q[1];
    assign pout.tx_idle_off = pin.link_10m & ~pin.tx_pending & ~cfg.pd;
    assign pout.tx_clk_en   = (state_q != pm_pkg::TX_LPI) & ~cfg.pd;
    assign pout.rx_clk_en   = ~rx_sleep & ~cfg.pd;
    assign pout.phy_pd      = cfg.pd;
    assign state            = state_q;

    // Checks
    chk_wake_next: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == pm_pkg::TX_LPI && pin.tx_pending) |=> !pout.tx_lpi)
        else $error("LPI not left after traffic");
    chk_no_lpi_slow: assert property (@(posedge pclk) disable iff (!presetn)
        pin.link_10m |=> !pout.tx_lpi)
        else $error("LPI on a 10 Mb/s link");
    chk_early_cancel: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == pm_pkg::TX_HOLD && cancel) |=> state_q == pm_pkg::TX_ACTIVE)
        else $error("Early cancel ignored");
    chk_recover_done: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(state_q == pm_pkg::TX_RECOVER) |-> $past(cnt_q) == '0)
        else $error("Recovery ended early");
    chk_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == pm_pkg::TX_LPI && pin.tx_pending) |=> !pout.tx_ready)
        else $error("Transmit released before recovery");

endmodule

// ---- design/core_power_ctrl.sv ----
`timescale 1ns/1ns
module core_power_ctrl (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Core events
    input  wire logic        wait_exec,
    input  wire logic        irq,
    input  wire logic        rp_bit,
    // Core controls
    output logic             asleep,
    output logic             core_clk_en,
    output logic             reduce_power_out_pin,
    output logic [31:0]      count
);

    logic        asleep_q;
    logic [31:0] count_q;

    // Wait state; an interrupt wins over a wait in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            asleep_q <= 1'b0;
        else if (irq)
            asleep_q <= 1'b0;
        else if (wait_exec)
            asleep_q <= 1'b1;
    end

    // Cycle count keeps running while the core sleeps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_q <= 32'h00000000;
        else
            count_q <= count_q + 32'h00000001;
    end

    assign asleep               = asleep_q;
    assign core_clk_en          = ~asleep_q;
    assign reduce_power_out_pin = rp_bit;
    assign count                = count_q;

    // Checks
    chk_irq_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (asleep_q && irq) |=> !asleep_q && core_clk_en)
        else $error("Core not woken by interrupt");
    chk_wait_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        (wait_exec && !irq) |=> !core_clk_en)
        else $error("Wait did not stop core clock");
    chk_count_runs: assert property (@(posedge pclk) disable iff (!presetn)
        asleep_q |=> count_q == $past(count_q) + 32'h00000001)
        else $error("Count stalled in wait");

endmodule

// ---- design/eee_lpi_power_control.sv ----
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module eee_lpi_power_control #(
    parameter int NPORTS      = 2,
    parameter int IDLE_CYC    = 64,
    parameter int EARLY_CYC   = 32,
    parameter int GS_TICK_CYC = pm_pkg::GS_TICK_CYC
) (
    // Clock and reset
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // APB slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic [31:0]                         prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Ethernet ports
    input  wire pm_pkg::port_in_t [NPORTS-1:0]  port_in,
    input  wire logic [NPORTS-1:0]              miim_pd,
    output pm_pkg::port_out_t [NPORTS-1:0]      port_out,
    output logic                                switch_clk_en,
    // Energy detect
    input  wire logic                           energy_seen,
    output logic                                pll_en,
    output logic                                mac_en,
    output logic                                phy_edet_only,
    // Processor core
    input  wire logic                           wait_exec,
    input  wire logic                           cpu_irq,
    output logic                                core_clk_en,
    output logic                                reduce_power_out_pin
);

    localparam int PSW = $clog2(GS_TICK_CYC);

    // Port register addresses, shared by decode and read-back
    function automatic logic [7:0] pctl_addr(input int i);
        return 8'(pm_pkg::A_PORT0 + i * pm_pkg::PORT_STRIDE);
    endfunction

    function automatic logic [7:0] rec_addr(input int i);
        return 8'(pctl_addr(i) + pm_pkg::REC_OFS);
    endfunction

    logic [1:0]               mode_q;
    logic [7:0]               sleep_q;
    logic                     rp_q;
    logic [7:0]               pctl_q [NPORTS];
    logic [7:0]               rec_q  [NPORTS];
    logic [31:0]              prdata_q;
    logic [31:0]              rdata_d;
    logic [NPORTS-1:0]        pc_hit;
    logic [NPORTS-1:0]        rc_hit;
    logic [NPORTS-1:0]        port_clk;
    logic [NPORTS-1:0]        deep_sleep;
    pm_pkg::port_cfg_t        cfg    [NPORTS];
    pm_pkg::tx_state_t        tstate [NPORTS];
    logic [PSW-1:0]           pre_q;
    logic [8:0]               gs_cnt_q;
    logic                     edet_low_q;
    logic                     cpu_asleep;
    logic                     cpu_clk;
    logic [31:0]              cyc_count;
    logic                     setup;
    logic                     access;
    logic                     wr;
    logic                     fixed_hit;
    logic                     mapped;
    logic                     edet_mode;
    logic                     gs_tick;
    logic [31:0]              stat_word;

    // APB phases; the slave always answers in the first access cycle
    assign setup     = psel & ~penable;
    assign access    = psel & penable;
    assign wr        = access & pwrite;
    assign fixed_hit = (paddr == pm_pkg::A_MODE) | (paddr == pm_pkg::A_SLEEP)
                     | (paddr == pm_pkg::A_STAT) | (paddr == pm_pkg::A_CPU)
                     | (paddr == pm_pkg::A_CNT);
    assign mapped    = fixed_hit | (|pc_hit) | (|rc_hit);
    assign pready    = 1'b1;
    assign pslverr   = access & ~mapped;
    assign prdata    = prdata_q;

    // Global registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q  <= pm_pkg::MODE_RST;
            sleep_q <= pm_pkg::SLEEP_RST;
            rp_q    <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == pm_pkg::A_MODE)
                mode_q <= pwdata[1:0];
            if (paddr == pm_pkg::A_SLEEP)
                sleep_q <= pwdata[7:0];
            if (paddr == pm_pkg::A_CPU)
                rp_q <= pwdata[pm_pkg::RP_BIT];
        end
    end

    // Per-port registers and low-power-idle controllers
    for (genvar i = 0; i < NPORTS; i++)
    begin : g_port
        assign pc_hit[i] = (paddr == pctl_addr(i));
        assign rc_hit[i] = (paddr == rec_addr(i));

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                pctl_q[i] <= pm_pkg::PCTL_RST;
                rec_q[i]  <= pm_pkg::REC_RST;
            end
            else
            begin
                if (wr && pc_hit[i])
                    pctl_q[i] <= pwdata[7:0];
                if (wr && rc_hit[i])
                    rec_q[i] <= pwdata[7:0];
            end
        end

        // Power-down from either the port control bit or management
        assign cfg[i].pd     = pctl_q[i][pm_pkg::PD_BIT] | miim_pd[i];
        assign cfg[i].lpi_en = pctl_q[i][pm_pkg::LPIEN_BIT];
        assign cfg[i].can_en = pctl_q[i][pm_pkg::CAN_HI:pm_pkg::CAN_LO];
        assign cfg[i].rec_us = rec_q[i];

        lpi_port_ctrl #(
            .IDLE_CYC  (IDLE_CYC),
            .EARLY_CYC (EARLY_CYC)
        ) u_port (
            .pclk    (pclk),
            .presetn (presetn),
            .cfg     (cfg[i]),
            .pin     (port_in[i]),
            .pout    (port_out[i]),
            .state   (tstate[i])
        );

        assign port_clk[i] = port_out[i].tx_clk_en | port_out[i].rx_clk_en;

        // Port fully asleep: transmit in LPI and receive clock gated
        assign deep_sleep[i] = port_out[i].tx_lpi & ~port_out[i].rx_clk_en;

        // A power-down write lands on its own port at once
        chk_pd_write: assert property (@(posedge pclk) disable iff (!presetn)
            (wr && pc_hit[i] && pwdata[pm_pkg::PD_BIT]) |=> port_out[i].phy_pd
            && !port_out[i].tx_ready)
            else $error("Port power-down write not applied");
    end

    // Switch core clock stops only when every port sleeps both ways or is powered down
    assign switch_clk_en = |port_clk;

    // Energy detect: count idle units, sleep once beyond go-sleep time
    assign edet_mode = (mode_q == pm_pkg::MODE_EDET);
    assign gs_tick   = (pre_q == PSW'(GS_TICK_CYC - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q      <= '0;
            gs_cnt_q   <= '0;
            edet_low_q <= 1'b0;
        end
        else if (!edet_mode || energy_seen)
        begin
            pre_q      <= '0;
            gs_cnt_q   <= '0;
            edet_low_q <= 1'b0;
        end
        else
        begin
            pre_q <= gs_tick ? '0 : pre_q + PSW'(1);
            if (gs_tick && gs_cnt_q != 9'h1FF)
                gs_cnt_q <= gs_cnt_q + 9'h001;
            if (gs_cnt_q > {1'b0, sleep_q})
                edet_low_q <= 1'b1;
        end
    end

    // Blocks disabled in the energy detect low-power state
    assign pll_en        = ~edet_low_q;
    assign mac_en        = ~edet_low_q;
    assign phy_edet_only = edet_low_q;

    // Processor core power control
    core_power_ctrl u_core (
        .pclk                 (pclk),
        .presetn              (presetn),
        .wait_exec            (wait_exec),
        .irq                  (cpu_irq),
        .rp_bit               (rp_q),
        .asleep               (cpu_asleep),
        .core_clk_en          (cpu_clk),
        .reduce_power_out_pin (reduce_power_out_pin),
        .count                (cyc_count)
    );

    assign core_clk_en = cpu_clk & ~edet_low_q;

    // Status word
    always_comb
    begin
        stat_word = '0;
        for (int i = 0; i < NPORTS; i++)
        begin
            stat_word[i*pm_pkg::ST_PORT_W +: 2] = tstate[i];
            stat_word[i*pm_pkg::ST_PORT_W + 2]  = ~port_out[i].rx_clk_en;
        end
        stat_word[pm_pkg::ST_EDET] = edet_low_q;
        stat_word[pm_pkg::ST_CPU]  = cpu_asleep;
    end

    // Read selection
    always_comb
    begin
        rdata_d = '0;
        if (paddr == pm_pkg::A_MODE)
            rdata_d = {30'h00000000, mode_q};
        if (paddr == pm_pkg::A_SLEEP)
            rdata_d = {24'h000000, sleep_q};
        if (paddr == pm_pkg::A_STAT)
            rdata_d = stat_word;
        if (paddr == pm_pkg::A_CPU)
            rdata_d = {31'h00000000, rp_q};
        if (paddr == pm_pkg::A_CNT)
            rdata_d = cyc_count;
        for (int i = 0; i < NPORTS; i++)
        begin
            if (pc_hit[i])
                rdata_d = {24'h000000, pctl_q[i]};
            if (rc_hit[i])
                rdata_d = {24'h000000, rec_q[i]};
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h00000000;
        else if (setup)
            prdata_q <= rdata_d;
    end

    // Checks
    chk_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == pm_pkg::A_MODE) |=> mode_q == $past(pwdata[1:0]))
        else $error("Mode field not written");
    chk_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(edet_low_q) |-> $past(edet_mode) && $past(gs_cnt_q) > {1'b0, $past(sleep_q)})
        else $error("Sleep before go-sleep time");
    chk_edet_off: assert property (@(posedge pclk) disable iff (!presetn)
        (edet_low_q && energy_seen) |=> pll_en && mac_en && !phy_edet_only)
        else $error("Energy did not restore power");
    chk_switch_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (&deep_sleep) |-> !switch_clk_en)
        else $error("Switch clock on while all ports sleep");
    chk_rp_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == pm_pkg::A_CPU) |=> reduce_power_out_pin == $past(pwdata[0]))
        else $error("Reduce-power pin not following bit");
    cov_port_lpi: cover property (@(posedge pclk) disable iff (!presetn)
        port_out[0].tx_lpi ##1 !port_out[0].tx_lpi);
    cov_edet_sleep: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(edet_low_q));
    cov_core_wait: cover property (@(posedge pclk) disable iff (!presetn)
        cpu_asleep ##1 !cpu_asleep);
    cov_early_cancel: cover property (@(posedge pclk) disable iff (!presetn)
        tstate[0] == pm_pkg::TX_HOLD ##1 tstate[0] == pm_pkg::TX_ACTIVE);
    cov_all_asleep: cover property (@(posedge pclk) disable iff (!presetn)
        &deep_sleep);

endmodule

// ---- sim/link_partner.sv ----
`timescale 1ns/1ns
module link_partner (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Bench requests and device pins
    input  wire logic [1:0] sleep_req,
    input  wire logic       core_clk_en,
    input  wire logic       reduce_power_out_pin,
    // Partner outputs
    output logic [1:0]      rx_lpi,
    output logic            gated_clk
);
    // Receive side sleeps one cycle after the bench asks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_lpi <= 2'h0;
        else
            rx_lpi <= sleep_req;
    end
    // Outside clock gate stops the core clock on the pin
    assign gated_clk = pclk & core_clk_en & ~reduce_power_out_pin;
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ns
module tb;
    logic                          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]                    paddr = 8'h00;
    logic [31:0]                   pwdata = 32'h0, prdata, r;
    logic                          pready, pslverr, e, sw_en, pll, mac, edo, cce, rpo, gclk;
    logic                          es = 1, wx = 0, irq = 0;
    logic [1:0]                    mpd = 2'h0, rxq = 2'h0, rxl;
    pm_pkg::port_in_t [1:0]        pi = '0, pin;
    pm_pkg::port_out_t [1:0]       po;
    int                            n_fail = 0, n_tests = 0, c;
    // Receive LPI comes from the partner
    always_comb
    begin
        pin = pi;
        pin[0].rx_lpi = rxl[0];
        pin[1].rx_lpi = rxl[1];
    end
    eee_lpi_power_control #(.NPORTS(2), .IDLE_CYC(4), .EARLY_CYC(3), .GS_TICK_CYC(4)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_in(pin), .miim_pd(mpd), .port_out(po), .switch_clk_en(sw_en), .energy_seen(es),
        .pll_en(pll), .mac_en(mac), .phy_edet_only(edo), .wait_exec(wx), .cpu_irq(irq),
        .core_clk_en(cce), .reduce_power_out_pin(rpo));
    link_partner lp (.pclk(pclk), .presetn(presetn), .sleep_req(rxq), .core_clk_en(cce),
        .reduce_power_out_pin(rpo), .rx_lpi(rxl), .gated_clk(gclk));
    // Clock
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    function automatic logic [7:0] ctl_a(int i);
        return 8'(pm_pkg::A_PORT0 + pm_pkg::PORT_STRIDE * i);
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        n_tests++;
        if (s !== x)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic finish_test();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #400000;
        n_fail++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        void'($urandom(19773));
        pi[0].tx_pending = 1; pi[1].tx_pending = 1;
        cyc(16);
        presetn <= 1;
        apb(0, pm_pkg::A_MODE, 0);  chk("mode", r, 32'h0);
        apb(0, ctl_a(1), 0);        chk("ctrl", r, 32'h01);
        apb(0, ctl_a(1) + pm_pkg::REC_OFS, 0); chk("rec", r, 32'h19);
        apb(0, 8'h24, 0);           chk("unmapped", {31'h0, e}, 32'h1);
        for (int k = 0; k < 8; k++)
        begin
            c = $urandom % 256;
            apb(1, pm_pkg::A_SLEEP, c);
            apb(0, pm_pkg::A_SLEEP, 0); chk("sleep", r, c);
        end
        // Idle port 0 sleeps, gates clocks, wakes and holds for recovery
        apb(1, ctl_a(0) + pm_pkg::REC_OFS, 32'h1);
        pi[0].tx_pending <= 0; pi[1].tx_pending <= 0; rxq <= 2'h3;
        cyc(12); chk("lpi", po[0].tx_lpi, 1); chk("txclk", po[0].tx_clk_en, 0);
        chk("swclk", sw_en, 0);
        apb(0, pm_pkg::A_STAT, 0); chk("st", r[7:0], 8'h66);
        pi[0].tx_pending <= 1; pi[1].tx_pending <= 1; rxq <= 2'h0;
        cyc(2); chk("wake", {po[0].tx_lpi, po[0].tx_ready}, 2'h0);
        chk("swclk1", sw_en, 1);
        c = 2;
        while (po[0].tx_ready !== 1'b1 && c < 2000)
        begin
            cyc(1); c++;
        end
        chk("recover", (c >= 1 * pm_pkg::US_CYC - 1 && c <= 1 * pm_pkg::US_CYC + 3), 1);
        // Enabled cancel event ends the early phase
        apb(1, ctl_a(0), 32'h11);
        pi[0].tx_pending <= 0;
        cyc(5); pi[0].cancel_evt <= 2'h1;
        cyc(20); chk("cancel", po[0].tx_lpi, 0);
        pi[0].tx_pending <= 1; pi[0].cancel_evt <= 2'h0;
        // 10M port: no LPI, idle transmitter off; rx sleeps while tx runs
        pi[1].link_10m <= 1; pi[1].tx_pending <= 0;
        cyc(15); chk("10m", {po[1].tx_lpi, po[1].tx_idle_off}, 2'h1);
        pi[1].link_10m <= 0; pi[1].tx_pending <= 1; rxq <= 2'h2;
        cyc(4); chk("rxonly", {po[1].rx_clk_en, po[1].tx_clk_en}, 2'h1);
        rxq <= 2'h0;
        // Power-down by bit and by management
        apb(1, ctl_a(1), 32'h09); cyc(1); chk("pd", po[1].phy_pd, 1);
        apb(1, ctl_a(1), 32'h01); mpd <= 2'h1; cyc(2); chk("mpd", po[0].phy_pd, 1);
        mpd <= 2'h0;
        // Core wait, count, interrupt and reduce-power pin
        wx <= 1; cyc(1); wx <= 0;
        cyc(1); chk("wait", cce, 0);
        apb(0, pm_pkg::A_CNT, 0); c = r;
        apb(0, pm_pkg::A_CNT, 0); chk("count", r - c, 3);
        irq <= 1; cyc(2); chk("irq", cce, 1); irq <= 0;
        apb(1, pm_pkg::A_CPU, 1); cyc(1); chk("rp", rpo, 1);
        chk("gclk", gclk, 0);
        apb(1, pm_pkg::A_CPU, 0); cyc(1); chk("rp0", rpo, 0);
        chk("gclk1", gclk, 1);
        // Energy detect low state and return
        apb(1, pm_pkg::A_SLEEP, 2); apb(1, pm_pkg::A_MODE, 1);
        es <= 0; cyc(30); chk("edet", {pll, mac, edo, cce}, 4'h2);
        es <= 1; cyc(3); chk("norm", {pll, mac, edo, cce}, 4'hD);
        finish_test();
    end
endmodule
